// ### hw/rnc_pkg.sv
package rnc_pkg;
   // Command codes
   localparam logic [15:0] CMD_RMW   = 16'h0020;
   localparam logic [15:0] CMD_STORE = 16'h00C4;
   localparam logic [15:0] CMD_BUFWR = 16'h008A;
   // Operation codes of the read-modify-write command
   localparam logic [2:0] OP_SET = 3'h0;
   localparam logic [2:0] OP_CLR = 3'h1;
   localparam logic [2:0] OP_AND = 3'h2;
   localparam logic [2:0] OP_XOR = 3'h3;
   localparam logic [2:0] OP_ADD = 3'h4;
   // Register file layout
   localparam int          NUM_REGS   = 256;
   localparam logic [7:0]  ACC_REG    = 8'h0A;
   localparam logic [7:0]  MULTI_LO   = 8'h0A;
   localparam logic [7:0]  MULTI_HI   = 8'hC7;
   localparam logic [15:0] MAX_COUNT  = 16'h000A;
   // Protected NV region: addresses below this bound
   localparam logic [15:0] NV_PROT_TOP = 16'h0040;
   // Status word bit positions
   localparam int ST_BIT12 = 12;
   localparam int ST_BIT14 = 14;
   localparam int INT_ST_ZERO = 0;
   localparam int INT_ST_NEG  = 1;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // Command as delivered by a parser, all words present
   typedef struct packed {
      logic [15:0] code;
      logic [15:0] p1;
      logic [15:0] p2;
      logic [31:0] data;
      logic        thread;
   } rnc_cmd_s;

   // Response to the issuer
   typedef struct packed {
      logic        ack;
      logic        hasData;
      logic        err;
      logic [31:0] data;
   } rnc_rsp_s;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_RMW   = 6'h02,
      ST_SLO   = 6'h04,
      ST_SHI   = 6'h08,
      ST_SSUM  = 6'h10,
      ST_DONE  = 6'h20
   } rnc_state_e;
endpackage

// ### hw/rnc_executor.sv
// Operation
// - RMW reads register then writes updated value
// - Ops: OR, clear, AND, XOR, add
// - RMW response returns pre-update register value
// - RMW code 32, operation, register, data
// - Store run sequentially to NV with checksum
// - NV address zero uses register 10
// - Each register stored as two 16-bit writes
// - Protected NV store sets status bits 12,14
// - Negative register continues past error, magnitude
// - Negative store sets status zero or negative
// - Store code 196: count, register, address
// - NV granted to one thread at a time
// - Buffer write overwrites two words from register
// - Buffer value copied without range check
// - Buffer write code 138: register, address
module rnc_executor (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              cmdValid,
   output logic                   cmdReady,
   input  wire rnc_pkg::rnc_cmd_s cmd,
   output rnc_pkg::rnc_rsp_s      rsp,
   output logic                   rspValid,
   output logic                   nvWe,
   output logic [15:0]            nvAddr,
   output logic [15:0]            nvData,
   output logic                   bufWe,
   output logic [15:0]            bufAddr,
   output logic [15:0]            bufData,
   input  wire logic              wrEn,
   input  wire logic [7:0]        wrSel,
   input  wire logic [31:0]       wrData,
   output logic [15:0]            statusWord,
   output logic [15:0]            intStatus0,
   output logic [15:0]            intStatus1,
   output logic                   haltReq
);
   rnc_pkg::rnc_state_e state;
   logic [31:0] regs [rnc_pkg::NUM_REGS];
   rnc_pkg::rnc_cmd_s   cur;
   logic [7:0]  curReg;
   logic [3:0]  left;
   logic [15:0] sum;
   logic        protHit;
   logic        softErr;
   logic        ownerThr;
   logic        isStore;
   logic        isBuf;
   logic [31:0] oldVal;
   logic [31:0] next_val;
   logic [15:0] mag;
   logic [15:0] next_addr;
   logic        badRange;

   // Apply an operation to a register value
   function automatic logic [31:0] apply_op(input logic [2:0] op,
                                            input logic [31:0] a,
                                            input logic [31:0] b);
      case (op)
         rnc_pkg::OP_SET: apply_op = a | b;
         rnc_pkg::OP_CLR: apply_op = a & ~b;
         rnc_pkg::OP_AND: apply_op = a & b;
         rnc_pkg::OP_XOR: apply_op = a ^ b;
         rnc_pkg::OP_ADD: apply_op = a + b;
         default:         apply_op = a;
      endcase
   endfunction

   // Decode of the incoming command
   assign isStore = (cmd.code == rnc_pkg::CMD_STORE);
   assign isBuf   = (cmd.code == rnc_pkg::CMD_BUFWR);
   assign mag     = cmd.p2[15] ? 16'(-cmd.p2) : cmd.p2;
   // Zero address redirects through the accumulator
   assign next_addr = (isStore && cmd.data[15:0] == 16'h0000) ?
                      regs[rnc_pkg::ACC_REG][15:0] : cmd.data[15:0];
   assign badRange  = (next_addr < rnc_pkg::NV_PROT_TOP);

   // One command at a time keeps NV owned by one thread
   assign cmdReady = (state == rnc_pkg::ST_IDLE);
   assign oldVal   = regs[cur.p2[7:0]];
   assign next_val = apply_op(cur.p1[2:0], oldVal, cur.data);

   // Sequencer for all three commands
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state    <= rnc_pkg::ST_IDLE;
         cur      <= '0;
         curReg   <= 8'h00;
         left     <= 4'h0;
         sum      <= 16'h0000;
         softErr  <= 1'b0;
         ownerThr <= 1'b0;
         nvAddr   <= 16'h0000;
         protHit  <= 1'b0;
      end else begin
         case (state)
            rnc_pkg::ST_IDLE: begin
               if (cmdValid) begin
                  cur      <= cmd;
                  ownerThr <= cmd.thread;
                  curReg   <= mag[7:0];
                  left     <= cmd.p1[3:0];
                  sum      <= 16'h0000;
                  softErr  <= cmd.p2[15];
                  nvAddr   <= next_addr;
                  protHit  <= isStore && badRange;
                  if (cmd.code == rnc_pkg::CMD_RMW)
                     state <= rnc_pkg::ST_RMW;
                  else if (isStore && !badRange)
                     state <= rnc_pkg::ST_SLO;
                  else
                     state <= rnc_pkg::ST_DONE;
               end
            end
            rnc_pkg::ST_RMW: state <= rnc_pkg::ST_DONE;
            rnc_pkg::ST_SLO: begin
               sum    <= sum + regs[curReg][15:0];
               nvAddr <= nvAddr + 16'h0001;
               state  <= rnc_pkg::ST_SHI;
            end
            rnc_pkg::ST_SHI: begin
               sum    <= sum + regs[curReg][31:16];
               nvAddr <= nvAddr + 16'h0001;
               curReg <= curReg + 8'h01;
               left   <= left - 4'h1;
               state  <= (left == 4'h1) ? rnc_pkg::ST_SSUM
                                        : rnc_pkg::ST_SLO;
            end
            rnc_pkg::ST_SSUM: state <= rnc_pkg::ST_DONE;
            rnc_pkg::ST_DONE: state <= rnc_pkg::ST_IDLE;
            default:          state <= rnc_pkg::ST_IDLE;
         endcase
      end
   end

   // NV write strobe: low half, high half, then checksum
   always_comb begin
      nvWe = 1'b0;
      case (state)
         rnc_pkg::ST_SLO:  nvWe = 1'b1;
         rnc_pkg::ST_SHI:  nvWe = 1'b1;
         rnc_pkg::ST_SSUM: nvWe = 1'b1;
         default:          nvWe = 1'b0;
      endcase
   end

   // NV data word, loaded on the edge that enters the state showing it,
   // so the memory sees a flip-flop rather than a read of the file
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nvData <= 16'h0000;
      end else begin
         case (state)
            rnc_pkg::ST_IDLE:
               nvData <= (cmdValid && isStore) ? regs[mag[7:0]][15:0]
                                               : 16'h0000;
            rnc_pkg::ST_SLO: nvData <= regs[curReg][31:16];
            rnc_pkg::ST_SHI:
               nvData <= (left == 4'h1) ? sum + regs[curReg][31:16]
                                        : regs[curReg + 8'h01][15:0];
            default: nvData <= 16'h0000;
         endcase
      end
   end

   // Program buffer longword write, two words, no range check
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bufWe   <= 1'b0;
         bufAddr <= 16'h0000;
         bufData <= 16'h0000;
      end else if (state == rnc_pkg::ST_IDLE && cmdValid && isBuf) begin
         bufWe   <= 1'b1;
         bufAddr <= cmd.p2;
         bufData <= regs[cmd.p1[7:0]][15:0];
      end else if (bufWe && state == rnc_pkg::ST_DONE &&
                   cur.code == rnc_pkg::CMD_BUFWR) begin
         bufAddr <= bufAddr + 16'h0001;
         bufData <= regs[cur.p1[7:0]][31:16];
      end else begin
         bufWe   <= 1'b0;
      end
   end

   // Register file; RMW update lands in the single RMW cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < rnc_pkg::NUM_REGS; i++)
            regs[i] <= rnc_pkg::REG_RESET;
      end else if (state == rnc_pkg::ST_RMW) begin
         regs[cur.p2[7:0]] <= next_val;
      end else if (wrEn && state != rnc_pkg::ST_SLO) begin
         regs[wrSel] <= wrData;                // Lost in RMW and SLO cycles
      end
   end

   // Response: old value for RMW, ACK only otherwise
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp      <= '0;
         rspValid <= 1'b0;
      end else if (state == rnc_pkg::ST_RMW) begin
         rsp      <= '{ack: 1'b1, hasData: 1'b1, err: 1'b0,
                       data: oldVal};
         rspValid <= 1'b1;
      end else if (state == rnc_pkg::ST_DONE &&
                   cur.code != rnc_pkg::CMD_RMW) begin
         rsp      <= '{ack: 1'b1, hasData: 1'b0,
                       err: protHit,
                       data: 32'h0000_0000};
         rspValid <= 1'b1;
      end else begin
         rspValid <= 1'b0;
      end
   end

   // Status word, internal status flags per thread, halt request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         statusWord <= 16'h0000;
         intStatus0 <= 16'h0000;
         intStatus1 <= 16'h0000;
         haltReq    <= 1'b0;
      end else begin
         haltReq <= 1'b0;
         if (state == rnc_pkg::ST_DONE &&
             cur.code == rnc_pkg::CMD_STORE) begin
            if (protHit) begin
               statusWord[rnc_pkg::ST_BIT12] <= 1'b1;
               statusWord[rnc_pkg::ST_BIT14] <= 1'b1;
               haltReq <= !softErr;
            end
            // Only the issuing thread sees its outcome
            if (softErr) begin
               if (ownerThr) begin
                  intStatus1[rnc_pkg::INT_ST_ZERO] <= !protHit;
                  intStatus1[rnc_pkg::INT_ST_NEG]  <= protHit;
               end else begin
                  intStatus0[rnc_pkg::INT_ST_ZERO] <= !protHit;
                  intStatus0[rnc_pkg::INT_ST_NEG]  <= protHit;
               end
            end
         end
      end
   end

   // Checks
   rmw_old_data_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_RMW |=> rspValid && rsp.data == $past(oldVal))
      else $error("RMW response not old value");
   rmw_update_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_RMW |=>
      regs[$past(cur.p2[7:0])] == $past(next_val))
      else $error("RMW update wrong");
   store_halves_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_SLO |=> state == rnc_pkg::ST_SHI && nvWe)
      else $error("Store high half missing");
   store_sum_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_SSUM |-> nvWe && nvData == sum)
      else $error("Checksum word wrong");
   prot_status_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_DONE && protHit |=>
      statusWord[12] && statusWord[14])
      else $error("Protect bits not set");
   halt_hard_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_DONE && protHit && !softErr |=> haltReq)
      else $error("Hard error did not halt");
   indirect_addr_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_IDLE && cmdValid && isStore &&
      cmd.data[15:0] == 16'h0000 |=>
      nvAddr == $past(regs[rnc_pkg::ACC_REG][15:0]))
      else $error("Indirect address not taken");
   one_owner_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state != rnc_pkg::ST_IDLE |-> !cmdReady)
      else $error("Second command accepted");
   ack_only_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      rspValid && !rsp.hasData |-> rsp.data == 32'h0000_0000)
      else $error("Ack carries data");
   soft_err_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_DONE && softErr |=> !haltReq)
      else $error("Soft error halted");
   buf_low_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      state == rnc_pkg::ST_IDLE && cmdValid && isBuf |=>
      bufWe && bufData == $past(regs[cmd.p1[7:0]][15:0]))
      else $error("Buffer low word wrong");
   buf_pair_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(bufWe) |=> bufWe && bufAddr == $past(bufAddr) + 16'h0001)
      else $error("Buffer second word missing");
   rmw_cov: cover property (@(posedge clk_sys) state == rnc_pkg::ST_RMW);
   store_cov: cover property (@(posedge clk_sys)
      state == rnc_pkg::ST_SSUM);
   buf_cov: cover property (@(posedge clk_sys) $rose(bufWe));
   prot_cov: cover property (@(posedge clk_sys) $rose(statusWord[12]));
   soft_cov: cover property (@(posedge clk_sys)
      state == rnc_pkg::ST_DONE && softErr && protHit);
endmodule

// ### bench/rnc_issuer.sv
module rnc_issuer (
   input  wire logic              clk_sys,
   input  wire logic              cmdReady,
   input  wire logic              rspValid,
   input  wire rnc_pkg::rnc_rsp_s rsp,
   output logic                   cmdValid,
   output rnc_pkg::rnc_cmd_s      cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   rnc_pkg::rnc_rsp_s lastRsp;
   logic              gotRsp;
   logic              busyLeak;

   // Idle bus until the first command
   initial begin
      cmdValid = 1'b0;
      cmd      = '0;
      gotRsp   = 1'b0;
      busyLeak = 1'b0;
   end

   // Offer one whole command, hold it until taken, then await the answer
   task automatic issue(input rnc_pkg::rnc_cmd_s c);
      int n;
      @(posedge clk_sys);
      #1;
      cmdValid = 1'b1;
      cmd      = c;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (cmdReady !== 1'b1 && n < 50);
      #1;
      cmdValid = 1'b0;
      cmd      = ~c; // Released bus must not show the last command
      gotRsp   = 1'b0;
      busyLeak = 1'b0;
      n = 0;
      // Ready while the answer is pending would let a second issuer in
      while (!gotRsp && n < 80) begin
         @(posedge clk_sys);
         n++;
         // Ready may return in the answer's own cycle
         if (rspValid === 1'b1) begin
            gotRsp  = 1'b1;
            lastRsp = rsp;
         end else if (cmdReady !== 1'b0) begin
            busyLeak = 1'b1;
         end
      end
      // Step off the edge so callers read settled outputs
      #1;
   endtask
endmodule

// ### bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk_sys = 1'b0;
   logic              rst     = 1'b1;
   logic              cmdValid, cmdReady, rspValid, nvWe, bufWe, haltReq;
   logic              wrEn;
   rnc_pkg::rnc_cmd_s cmd;
   rnc_pkg::rnc_rsp_s rsp;
   logic [15:0]       nvAddr, nvData, bufAddr, bufData;
   logic [15:0]       statusWord, intStatus0, intStatus1;
   logic [7:0]        wrSel;
   logic [31:0]       wrData;
   logic [31:0]       nvLog[$];
   logic [31:0]       bufLog[$];
   logic              haltSeen = 1'b0;
   int                n_errors = 0;
   int                total_checks = 0;
   int                cycles = 0;

   always #5 clk_sys = ~clk_sys;

   rnc_executor DUT (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmd(cmd), .rsp(rsp), .rspValid(rspValid),
      .nvWe(nvWe), .nvAddr(nvAddr), .nvData(nvData), .bufWe(bufWe),
      .bufAddr(bufAddr), .bufData(bufData), .wrEn(wrEn), .wrSel(wrSel),
      .wrData(wrData), .statusWord(statusWord), .intStatus0(intStatus0),
      .intStatus1(intStatus1), .haltReq(haltReq));

   rnc_issuer issuer (.clk_sys(clk_sys), .cmdReady(cmdReady),
      .rspValid(rspValid), .rsp(rsp), .cmdValid(cmdValid), .cmd(cmd));

   // Log memory and buffer writes as address over data; cap the run
   always @(posedge clk_sys) begin
      cycles++;
      if (nvWe === 1'b1) nvLog.push_back({nvAddr, nvData});
      if (bufWe === 1'b1) bufLog.push_back({bufAddr, bufData});
      if (haltReq === 1'b1) haltSeen = 1'b1;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask

   // Answer flags ack, data present, error
   task automatic flags(input logic [2:0] e);
      check("answer", {28'h0, 1'b1, e},
            {28'h0, issuer.gotRsp, issuer.lastRsp.ack,
            issuer.lastRsp.hasData, issuer.lastRsp.err});
   endtask

   task automatic pop(input bit isBuf, input logic [15:0] a, d);
      logic [31:0] g;
      g = 32'hXXXX_XXXX;
      if (!isBuf && nvLog.size() > 0) g = nvLog.pop_front();
      if (isBuf && bufLog.size() > 0) g = bufLog.pop_front();
      check("write", {a, d}, g);
   endtask

   task automatic set_reg(input logic [7:0] r, input logic [31:0] v);
      @(posedge clk_sys);
      #1;
      wrEn   = 1'b1;
      wrSel  = r;
      wrData = v;
      @(posedge clk_sys);
      #1;
      wrEn   = 1'b0;
   endtask

   function automatic rnc_pkg::rnc_cmd_s mk(input logic [15:0] c, p1, p2,
                                            input logic [31:0] d,
                                            input logic t);
      mk = '{c, p1, p2, d, t};
   endfunction

   // Chain all operations on one register; each answer shows the old value
   task automatic test_rmw();
      logic [31:0] v;
      logic [31:0] o [5];
      v = 32'h0000_00F0;
      o = '{32'h0000_0F00, 32'h0000_0030, 32'h0000_0F80, 32'h0000_0001,
            32'hFFFF_FF80};
      set_reg(8'h0C, v);
      for (int i = 0; i < 6; i++) begin
         issuer.issue(mk(rnc_pkg::CMD_RMW, 16'(i % 5), 16'h000C, o[i % 5],
                         1'b0));
         check("old value", v, issuer.lastRsp.data);
         flags(3'b110);
         case (i % 5)
            0: v = v | o[0];
            1: v = v & ~o[1];
            2: v = v & o[2];
            3: v = v ^ o[3];
            default: v = v + o[4];
         endcase
      end
   endtask

   // Two registers, halves low first, then checksum of all halves
   task automatic test_store();
      logic [31:0] r [2];
      logic [15:0] s;
      r = '{32'h1234_ABCD, 32'h0F0F_8001};
      s = 16'h0000;
      set_reg(8'h14, r[0]);
      set_reg(8'h15, r[1]);
      nvLog.delete();
      issuer.issue(mk(rnc_pkg::CMD_STORE, 16'h0002, 16'h0014, 32'h0000_0100,
                      1'b0));
      flags(3'b100);
      check("busy", 32'h0, {31'h0, issuer.busyLeak});
      for (int i = 0; i < 2; i++) begin
         pop(1'b0, 16'(16'h0100 + 2 * i), r[i][15:0]);
         pop(1'b0, 16'(16'h0101 + 2 * i), r[i][31:16]);
         s = s + r[i][15:0] + r[i][31:16];
      end
      pop(1'b0, 16'h0104, s);
   endtask

   // Protected target: hard error, then the soft form on thread 1
   task automatic test_protect();
      nvLog.delete();
      haltSeen = 1'b0;
      issuer.issue(mk(rnc_pkg::CMD_STORE, 16'h0001, 16'h0005, 32'h0000_0010,
                      1'b0));
      flags(3'b101);
      check("status", 32'h3, {30'h0, statusWord[14], statusWord[12]});
      check("halt", 32'h1, {31'h0, haltSeen});
      check("nv count", 32'h0, 32'(nvLog.size()));
      haltSeen = 1'b0;
      issuer.issue(mk(rnc_pkg::CMD_STORE, 16'h0001, 16'hFFFB, 32'h0000_0010,
                      1'b1));
      flags(3'b101);
      check("soft halt", 32'h0, {31'h0, haltSeen});
      check("flags fail", 32'h2, {30'h0, intStatus1[1:0]});
   endtask

   // Indirect address from register 10, soft form that succeeds
   task automatic test_indirect();
      set_reg(8'h0A, 32'h0000_0200);
      set_reg(8'h1E, 32'hCAFE_0001);
      nvLog.delete();
      haltSeen = 1'b0;
      issuer.issue(mk(rnc_pkg::CMD_STORE, 16'h0001, 16'hFFE2, 32'h0000_0000,
                      1'b0));
      flags(3'b100);
      pop(1'b0, 16'h0200, 16'h0001);
      pop(1'b0, 16'h0201, 16'hCAFE);
      pop(1'b0, 16'h0202, 16'hCAFF);
      check("flags ok", 32'h1, {30'h0, intStatus0[1:0]});
      check("other thread", 32'h2, {30'h0, intStatus1[1:0]});
      check("ok halt", 32'h0, {31'h0, haltSeen});
   endtask

   // Out-of-range longword lands in two buffer words unchecked
   task automatic test_buffer();
      set_reg(8'h28, 32'hFFFF_8000);
      bufLog.delete();
      issuer.issue(mk(rnc_pkg::CMD_BUFWR, 16'h0028, 16'h007A, 32'h0000_0000,
                      1'b1));
      flags(3'b100);
      pop(1'b1, 16'h007A, 16'h8000);
      pop(1'b1, 16'h007B, 16'hFFFF);
   endtask

   // Mid-run reset clears sticky status, flags and registers
   task automatic test_reset();
      @(posedge clk_sys);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      check("status reset", 32'h0, {16'h0, statusWord});
      check("flags reset", 32'h0, {16'h0, intStatus1});
      issuer.issue(mk(rnc_pkg::CMD_RMW, 16'h0000, 16'h000C, 32'h0000_0001,
                      1'b0));
      flags(3'b110);
      check("old after reset", 32'h0, issuer.lastRsp.data);
   endtask

   // Reset, then each scenario in turn
   initial begin
      wrEn   = 1'b0;
      wrSel  = 8'h00;
      wrData = 32'h0000_0000;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      test_rmw();
      test_store();
      test_protect();
      test_indirect();
      test_buffer();
      test_reset();
      print_verdict();
   end
endmodule
